//--- logic/pss_regs.svh
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// How it works
// - accumulator then optional phase offset adder
// - step and shift each fixed, programmed, streamed
// - fixed step ignores every run-time input
// - write bus: channel address, selector, enable, data
// - selector 0 is step, 1 is shift
// - selector used only when both programmable
// - address width follows channel count, up to 16
// - address used only if programmable and multichannel
// - write enable high stores data word
// - writes succeed while clock enable low
// - data width equals phase width, angle modulo
// - host puts short values in top bits
// - table-only mode converts external phase input
// - table stores quarter wave, symmetry rebuilds rest
// - sine, cosine presence and negation build options
// - optional first-order correction from fraction bits
// - optional dither between accumulator and table
// - controls active high except reset rst_n_in (active low), rising edge clock
// - time-multiplexed channels with own step, shift
// - clear resets accumulator, counter, keeps registers
// - valid marks samples, qualifies channel index
`define PSS_SEL_STEP 1'b0
`define PSS_SEL_SHIFT 1'b1
`define PSS_LUT_BITS 8
`define PSS_FRAC_BITS 4
`define PSS_LFSR_SEED 16'hace1
`define PSS_LFSR_TAPS 16'hb400
`endif

//--- logic/pss_pkg.sv
package pss_pkg;
  typedef enum {PSS_SRC_FIXED, PSS_SRC_PROG, PSS_SRC_STREAM} pss_src_t;
  typedef enum {PSS_MODE_DDS, PSS_MODE_PHASE_ONLY, PSS_MODE_LUT_ONLY} pss_mode_t;
  typedef enum {PSS_HOST_IDLE, PSS_HOST_STEP, PSS_HOST_SHIFT} pss_host_st_t;
endpackage : pss_pkg

//--- logic/pss_link_if.sv
`timescale 1ns/1ps
interface pss_link_if #(
  parameter int N = 16,
  parameter int M = 2,
  parameter int P = 12
) (
  input wire logic clk_in
);
  logic [M-1:0] addr;
  logic reg_sel;
  logic we;
  logic [N-1:0] data;
  logic ce;
  logic sync_clear;
  logic [N-1:0] phase_step_stream;
  logic [N-1:0] phase_shift_stream;
  logic [N-1:0] phase_in;
  logic rdy;
  logic [M-1:0] channel;
  logic [P-1:0] sine;
  logic [P-1:0] cosine;
  logic [N-1:0] phase_out;
  modport dev (input addr, reg_sel, we, data, ce, sync_clear, phase_step_stream, phase_shift_stream,
    phase_in, output rdy, channel, sine, cosine, phase_out);
  modport host (output addr, reg_sel, we, data, ce, sync_clear, phase_step_stream, phase_shift_stream,
    phase_in, input rdy, channel, sine, cosine, phase_out);
endinterface : pss_link_if

//--- logic/pss_synth.sv
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_synth import pss_pkg::*; #(
  parameter int N = 16,
  parameter int CHANNELS = 2,
  parameter int M = 2,
  parameter int P = 12,
  parameter pss_mode_t MODE = PSS_MODE_DDS,
  parameter pss_src_t STEP_SRC = PSS_SRC_PROG,
  parameter pss_src_t SHIFT_SRC = PSS_SRC_PROG,
  parameter logic [N-1:0] STEP_FIXED = 16'h0100,
  parameter logic [N-1:0] SHIFT_FIXED = 16'h0000,
  parameter bit HAS_SHIFT = 1'b1,
  parameter bit HAS_SINE = 1'b1,
  parameter bit HAS_COSINE = 1'b1,
  parameter bit NEG_SINE = 1'b0,
  parameter bit NEG_COSINE = 1'b0,
  parameter bit DITHER = 1'b0,
  parameter bit TAYLOR = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  pss_link_if.dev link
);
  localparam int L = `PSS_LUT_BITS;
  localparam int F = `PSS_FRAC_BITS;
  localparam int AW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
  localparam bit MULTI = (CHANNELS > 1) && (STEP_SRC == PSS_SRC_PROG || SHIFT_SRC == PSS_SRC_PROG);
  localparam bit BOTH_PROG = (STEP_SRC == PSS_SRC_PROG) && (SHIFT_SRC == PSS_SRC_PROG);
  localparam int QD = 1 << (L - 2);

  // quarter-wave sine amplitude of index i in [0, QD]
  function automatic logic [P-1:0] qsin(input int i);
    real v;
    v = $sin(3.14159265358979 * i / (2.0 * QD)) * ((1 << (P - 1)) - 1);
    return P'($rtoi(v + 0.5));
  endfunction : qsin

  // rebuild full wave from quarter symmetry of the L top phase bits
  function automatic logic signed [P-1:0] wave(input logic [L-1:0] ph);
    logic [L-3:0] k;
    logic [P-1:0] a;
    k = ph[L-3:0];
    a = ph[L-2] ? qsin(QD - int'(k)) : qsin(int'(k));
    return ph[L-1] ? -$signed(a) : $signed(a);
  endfunction : wave

  logic [N-1:0] step_q [CHANNELS];
  logic [N-1:0] shift_q [CHANNELS];
  logic [N-1:0] acc_q [CHANNELS];
  logic [AW-1:0] chan_q;
  logic [AW-1:0] out_chan_q;
  logic rdy_q;
  logic [N-1:0] phase_q;
  logic [P-1:0] sine_q;
  logic [P-1:0] cosine_q;
  logic [15:0] lfsr_q;

  wire [AW-1:0] wr_chan = MULTI ? AW'(link.addr) : '0;
  wire wr_is_shift = BOTH_PROG ? (link.reg_sel == `PSS_SEL_SHIFT) : (SHIFT_SRC == PSS_SRC_PROG);
  wire [AW-1:0] chan_next = (int'(chan_q) == CHANNELS - 1) ? '0 : AW'(chan_q + 1'b1);
  wire [N-1:0] cur_step = (STEP_SRC == PSS_SRC_FIXED) ? STEP_FIXED :
                          (STEP_SRC == PSS_SRC_STREAM) ? link.phase_step_stream : step_q[chan_q];
  wire [N-1:0] cur_shift = !HAS_SHIFT ? '0 : (SHIFT_SRC == PSS_SRC_FIXED) ? SHIFT_FIXED :
                           (SHIFT_SRC == PSS_SRC_STREAM) ? link.phase_shift_stream : shift_q[chan_q];
  wire [N-1:0] acc_next = N'(acc_q[chan_q] + cur_step);
  wire [N-1:0] gen_phase = N'(acc_q[chan_q] + cur_shift);
  wire [N-1:0] src_phase = (MODE == PSS_MODE_LUT_ONLY) ? link.phase_in : gen_phase;
  wire [N-1:0] dith = DITHER ? N'(lfsr_q[F-1:0]) : '0;
  wire [N-1:0] lut_phase = (MODE == PSS_MODE_DDS) ? N'(src_phase + dith) : src_phase;
  wire [L-1:0] idx = lut_phase[N-1 -: L];
  wire [F-1:0] frac = lut_phase[N-L-1 -: F];
  wire signed [P-1:0] s_raw = wave(idx);
  wire signed [P-1:0] c_raw = wave(L'(idx + L'(1 << (L - 2))));
  // first-order term: d sin = cos * dphi, dphi scaled by 2*pi/2^L
  wire signed [P+F+1:0] s_corr = (P+F+2)'((c_raw * $signed({1'b0, frac}) * 6) >>> (L + F));
  wire signed [P+F+1:0] c_corr = (P+F+2)'((s_raw * $signed({1'b0, frac}) * 6) >>> (L + F));
  wire signed [P-1:0] s_fix = TAYLOR ? P'(s_raw + P'(s_corr)) : s_raw;
  wire signed [P-1:0] c_fix = TAYLOR ? P'(c_raw - P'(c_corr)) : c_raw;
  wire [P-1:0] s_out = !HAS_SINE ? '0 : NEG_SINE ? P'(-s_fix) : s_fix;
  wire [P-1:0] c_out = !HAS_COSINE ? '0 : NEG_COSINE ? P'(-c_fix) : c_fix;

  // writes ignore ce and clear: registers are not part of the datapath state
  always_ff @(posedge clk_in) begin
    if (link.we) begin
      if (wr_is_shift) shift_q[wr_chan] <= link.data;
      else if (STEP_SRC == PSS_SRC_PROG) step_q[wr_chan] <= link.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || link.sync_clear) begin
      chan_q <= '0;
      rdy_q <= 1'b0;
      lfsr_q <= `PSS_LFSR_SEED;
      for (int i = 0; i < CHANNELS; i++) acc_q[i] <= '0;
    end else if (link.ce) begin
      acc_q[chan_q] <= acc_next;
      chan_q <= chan_next;
      rdy_q <= 1'b1;
      lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `PSS_LFSR_TAPS) : (lfsr_q >> 1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (link.ce) begin
      out_chan_q <= chan_q;
      phase_q <= gen_phase;
      sine_q <= s_out;
      cosine_q <= c_out;
    end
  end

  assign link.rdy = rdy_q;
  assign link.channel = (CHANNELS > 1) ? M'(out_chan_q) : '0;
  assign link.phase_out = phase_q;
  assign link.sine = sine_q;
  assign link.cosine = cosine_q;
endmodule : pss_synth

//--- logic/pss_host.sv
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_host import pss_pkg::*; #(
  parameter int N = 16,
  parameter int M = 2,
  parameter int P = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  pss_link_if.host link,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic wr_step_in,
  input wire logic wr_shift_in,
  input wire logic [M-1:0] wr_chan_in,
  input wire logic [N-1:0] wr_value_in,
  input wire logic [N-1:0] step_stream_in,
  input wire logic [N-1:0] shift_stream_in,
  input wire logic [N-1:0] phase_in,
  output logic busy_out,
  output logic sample_valid_out,
  output logic [M-1:0] sample_chan_out,
  output logic [P-1:0] sample_sine_out,
  output logic [P-1:0] sample_cosine_out
);
  pss_host_st_t st_q;
  logic [M-1:0] addr_q;
  logic [N-1:0] data_q;
  logic we_q;
  logic sel_q;
  logic v_q;
  logic fresh_q;
  logic [M-1:0] ch_q;
  logic [P-1:0] s_q;
  logic [P-1:0] c_q;

  wire go_step = wr_step_in;
  wire go_shift = !wr_step_in && wr_shift_in;

  // one-cycle write; caller left-aligns short values into the top data bits
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q <= PSS_HOST_IDLE;
      we_q <= 1'b0;
      sel_q <= `PSS_SEL_STEP;
      addr_q <= '0;
      data_q <= '0;
    end else begin
      we_q <= go_step || go_shift;
      sel_q <= go_shift ? `PSS_SEL_SHIFT : `PSS_SEL_STEP;
      addr_q <= wr_chan_in;
      data_q <= wr_value_in;
      unique case (st_q)
        PSS_HOST_IDLE: st_q <= go_step ? PSS_HOST_STEP : go_shift ? PSS_HOST_SHIFT : PSS_HOST_IDLE;
        PSS_HOST_STEP, PSS_HOST_SHIFT: st_q <= go_step ? PSS_HOST_STEP : go_shift ? PSS_HOST_SHIFT : PSS_HOST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      v_q <= 1'b0;
      fresh_q <= 1'b0;
      ch_q <= '0;
      s_q <= '0;
      c_q <= '0;
    end else begin
      // a standing sample held by ce low is not new, so only an enabled edge marks one
      fresh_q <= link.ce && !link.sync_clear;
      v_q <= link.rdy && fresh_q;
      if (link.rdy && fresh_q) begin
        ch_q <= link.channel;
        s_q <= link.sine;
        c_q <= link.cosine;
      end
    end
  end

  assign link.we = we_q;
  assign link.reg_sel = sel_q;
  assign link.addr = addr_q;
  assign link.data = data_q;
  assign link.ce = rst_n_in && run_in;
  assign link.sync_clear = !rst_n_in || clear_in;
  assign link.phase_step_stream = step_stream_in;
  assign link.phase_shift_stream = shift_stream_in;
  assign link.phase_in = phase_in;
  assign busy_out = (st_q != PSS_HOST_IDLE);
  assign sample_valid_out = v_q;
  assign sample_chan_out = ch_q;
  assign sample_sine_out = s_q;
  assign sample_cosine_out = c_q;
endmodule : pss_host

//--- verif/pss_synth_checker.sv
`timescale 1ns/1ps
module pss_synth_checker #(
  parameter int N = 16,
  parameter int M = 2,
  parameter int CHANNELS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [M-1:0] addr,
  input wire logic reg_sel,
  input wire logic we,
  input wire logic [N-1:0] data,
  input wire logic ce,
  input wire logic sync_clear,
  input wire logic rdy,
  input wire logic [M-1:0] channel,
  input wire logic [N-1:0] phase_out
);
  logic [N-1:0] stp_q [CHANNELS];
  logic [N-1:0] shf_q [CHANNELS];
  localparam int CW = $clog2(CHANNELS);
  wire [CW-1:0] wa_w = addr[CW-1:0];
  wire [CW-1:0] ca_w = channel[CW-1:0];
  wire run_w = ce && !sync_clear;
  wire [M-1:0] nxt_w = (channel == M'(CHANNELS - 1)) ? '0 : channel + 1'b1;
  // shadow of the write bus, so phase checks need no accumulator model
  always_ff @(posedge clk_in) begin
    if (we && !reg_sel) stp_q[wa_w] <= data;
    if (we && reg_sel) shf_q[wa_w] <= data;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_CLEAR_DROPS_RDY: assert property (sync_clear |=> !rdy) else $error("rdy after clear");
  AST_RDY_AFTER_RUN: assert property (run_w |=> rdy) else $error("no rdy after run");
  AST_CHAN_RANGE: assert property (rdy |-> channel < CHANNELS) else $error("channel out of range");
  AST_ROUND_ROBIN: assert property (rdy && run_w |=> channel == $past(nxt_w)) else $error("channel order");
  AST_FIRST_CHAN: assert property ((sync_clear ##1 run_w) |=> channel == '0) else $error("first channel");
  AST_HOLD_NO_CE: assert property (rdy && !ce && !sync_clear |=> $stable(phase_out) && $stable(channel))
    else $error("outputs moved with ce low");
  AST_FIRST_PHASE: assert property ((sync_clear ##1 run_w && !we) |=> phase_out == shf_q[0])
    else $error("first phase not shift");
  // two-channel stepping only: the same channel returns two services later
  AST_PHASE_STEP: assert property ((rdy && run_w && $past(run_w) && !we && !$past(we) ##1 run_w && !we)
    |=> phase_out == $past(phase_out, 2) + stp_q[ca_w]) else $error("phase step");
  cover property (sync_clear ##1 run_w);
  cover property (we && reg_sel);
  cover property (rdy && !ce);
endmodule : pss_synth_checker

//--- verif/pss_synth_tb_top.sv
`timescale 1ns/1ps
module pss_synth_tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, run_in = 1'b0, clear_in = 1'b0;
  logic wr_step_in = 1'b0, wr_shift_in = 1'b0, adv_q = 1'b0, busy_out, sample_valid_out;
  logic [1:0] wr_chan_in = 2'h0, exp_ch = 2'h0, sample_chan_out;
  logic [15:0] wr_value_in = 16'h0000, zero_w = 16'h0000;
  logic [11:0] sample_sine_out, sample_cosine_out;
  logic [15:0] stp_e [2];
  logic [15:0] shf_e [2];
  int cnt [2];
  int n_samp = 0, n_hv = 0, n_fail = 0, n_compared = 0;
  logic hv_due = 1'b0;
  logic [1:0] hv_ch = 2'h0;
  logic [15:0] exp_ph = 16'h0000;
  logic [23:0] hv_wave = 24'h000000;
  always #2 clk_in = ~clk_in;
  pss_link_if #(.N(16), .M(2), .P(12)) pss_link_if_i (.clk_in(clk_in));
  pss_synth pss_synth_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(pss_link_if_i));
  pss_host pss_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(pss_link_if_i), .run_in(run_in),
    .clear_in(clear_in), .wr_step_in(wr_step_in), .wr_shift_in(wr_shift_in), .wr_chan_in(wr_chan_in),
    .wr_value_in(wr_value_in), .step_stream_in(zero_w), .shift_stream_in(zero_w), .phase_in(zero_w),
    .busy_out(busy_out), .sample_valid_out(sample_valid_out), .sample_chan_out(sample_chan_out),
    .sample_sine_out(sample_sine_out), .sample_cosine_out(sample_cosine_out));
  pss_synth_checker pss_synth_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr(pss_link_if_i.addr),
    .reg_sel(pss_link_if_i.reg_sel), .we(pss_link_if_i.we), .data(pss_link_if_i.data), .ce(pss_link_if_i.ce),
    .sync_clear(pss_link_if_i.sync_clear), .rdy(pss_link_if_i.rdy), .channel(pss_link_if_i.channel),
    .phase_out(pss_link_if_i.phase_out));
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // {sine, cosine} at a quadrant start; exact only because channel 1 stays on quadrant starts
  function automatic logic [23:0] quarter_wave(input logic [15:0] ph);
    case (ph[15:14])
      2'h0: return {12'h000, 12'h7ff};
      2'h1: return {12'h7ff, 12'h000};
      2'h2: return {12'h000, 12'h801};
      default: return {12'h801, 12'h000};
    endcase
  endfunction : quarter_wave
  task automatic stall(input string name);
    n_fail++;
    $display("[ERR] %s expected done seen timeout", name);
    results();
  endtask : stall
  task automatic wr(input logic sel, input logic [1:0] ch, input logic [15:0] v);
    int i;
    @(posedge clk_in);
    wr_chan_in <= ch;
    wr_value_in <= v;
    wr_step_in <= ~sel;
    wr_shift_in <= sel;
    @(posedge clk_in);
    wr_step_in <= 1'b0;
    wr_shift_in <= 1'b0;
    #1;
    chk("busy", 16'h0001, {15'h0000, busy_out});
    for (i = 0; i < 20 && busy_out !== 1'b0; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (busy_out !== 1'b0) stall("busy");
    // late update: the monitor may still check a sample launched before this write
    if (sel) shf_e[ch] = v;
    else stp_e[ch] = v;
  endtask : wr
  task automatic clear;
    @(posedge clk_in);
    clear_in <= 1'b1;
    @(posedge clk_in);
    clear_in <= 1'b0;
  endtask : clear
  task automatic run(input int n);
    int i;
    int goal;
    goal = n_samp + n;
    run_in <= 1'b1;
    for (i = 0; i < 100 && n_samp < goal; i++) @(posedge clk_in);
    if (n_samp < goal) stall("samples");
  endtask : run
  // reads pre-edge values; expectation restarts whenever clear reaches the link
  always @(posedge clk_in) begin
    if (sample_valid_out === 1'b1) n_hv++;
    if (hv_due) begin
      chk("host_valid", 16'h0001, {15'h0000, sample_valid_out});
      chk("host_chan", {14'h0000, hv_ch}, {14'h0000, sample_chan_out});
      if (hv_ch[0]) chk("host_sine", {4'h0, hv_wave[23:12]}, {4'h0, sample_sine_out});
      if (hv_ch[0]) chk("host_cosine", {4'h0, hv_wave[11:0]}, {4'h0, sample_cosine_out});
    end
    hv_due = 1'b0;
    if (pss_link_if_i.sync_clear === 1'b1) begin
      cnt = '{0, 0};
      exp_ch = 2'h0;
    end else if (adv_q && pss_link_if_i.rdy === 1'b1) begin
      exp_ph = 16'(shf_e[exp_ch[0]] + stp_e[exp_ch[0]] * cnt[exp_ch[0]]);
      chk("channel", {14'h0000, exp_ch}, {14'h0000, pss_link_if_i.channel});
      chk("phase", exp_ph, pss_link_if_i.phase_out);
      hv_wave = quarter_wave(exp_ph);
      hv_ch = exp_ch;
      hv_due = 1'b1;
      if (exp_ch[0]) chk("sine", {4'h0, hv_wave[23:12]}, {4'h0, pss_link_if_i.sine});
      if (exp_ch[0]) chk("cosine", {4'h0, hv_wave[11:0]}, {4'h0, pss_link_if_i.cosine});
      cnt[exp_ch[0]]++;
      exp_ch = {1'b0, ~exp_ch[0]};
      n_samp++;
    end
    adv_q = pss_link_if_i.ce === 1'b1 && pss_link_if_i.sync_clear !== 1'b1;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(1'b0, 2'h0, 16'h1234);
    wr(1'b1, 2'h0, 16'h0010);
    wr(1'b0, 2'h1, 16'hc000);
    wr(1'b1, 2'h1, 16'h8001);
    clear();
    run(8);
    $display("test 1 done: two channels");
    clear();
    run(6);
    $display("test 2 done: clear while running");
    run_in <= 1'b0;
    wr(1'b0, 2'h1, 16'h0001);
    wr(1'b1, 2'h0, 16'he000);
    clear();
    run(8);
    run_in <= 1'b0;
    chk("host_samples", 16'h0001, {15'h0000, n_hv > 0});
    $display("test 3 done: rewrite after stop");
    results();
  end
endmodule : pss_synth_tb_top
